// file: rtl/somc_defs.svh
// Purpose: Constants of the operating-mode controller
// Assumes: pclk at 200 MHz
// Notes:   Start latencies in ns, derived cycle counts below
`ifndef SOMC_DEFS_SVH
`define SOMC_DEFS_SVH
`define SOMC_CLK_PERIOD_NS    5
`define SOMC_ACT_START_NS     10000
`define SOMC_STBY_START_NS    35000
`define SOMC_ACT_START_CYC    (`SOMC_ACT_START_NS / `SOMC_CLK_PERIOD_NS)
`define SOMC_STBY_START_CYC   (`SOMC_STBY_START_NS / `SOMC_CLK_PERIOD_NS)
`define SOMC_CFG_STBY_CYC     2000
`define SOMC_WAKE_CYC         4000
`define SOMC_MEAS_BASE_CYC    200
`define SOMC_LF_TICK_CYC      200000
`define SOMC_ADDR_CTRL        12'h000
`define SOMC_ADDR_CONV        12'h004
`define SOMC_ADDR_ALERT       12'h008
`define SOMC_ADDR_STATUS      12'h00C
`define SOMC_ADDR_RESULT      12'h010
`define SOMC_CTRL_RST         32'h00000000
`define SOMC_CONV_RST         32'h00000007
`define SOMC_ALERT_RST        32'h00000000
`define SOMC_CODE_CFG         3'h0
`define SOMC_CODE_STBY        3'h1
`define SOMC_CODE_ACT_CONT    3'h2
`define SOMC_CODE_ACT_TRIG    3'h3
`define SOMC_CODE_WAKE_SLEEP  3'h4
`define SOMC_CODE_SLEEP       3'h5
`define SOMC_CODE_DEEP_SLEEP  3'h6
`endif

// file: rtl/somc_pkg.sv
// Purpose: Types of the operating-mode controller
// Assumes: nothing
// Notes:   State codes written out
package somc_pkg;
	typedef enum logic [2:0] {
		SOMC_CFG   = 3'h0,
		SOMC_STBY  = 3'h1,
		SOMC_ACT   = 3'h2,
		SOMC_WAKES = 3'h3,
		SOMC_SLEEP = 3'h4,
		SOMC_DEEP  = 3'h5,
		SOMC_WAKEUP = 3'h6
	} somc_state_t;
	typedef enum logic [1:0] {
		SOMC_TRIG_REG   = 2'h0,
		SOMC_TRIG_CS    = 2'h1,
		SOMC_TRIG_ALERT = 2'h2,
		SOMC_TRIG_NONE  = 2'h3
	} somc_trig_t;
endpackage

// file: rtl/somc_top.sv
// Purpose: Operating-state controller of a 3D Hall sensor, APB slave
// Assumes: cs and alert pins asynchronous, conversion core external
// Notes:   Zero-wait APB, errors on unmapped addresses
//
// Behaviour
// R1 - After reset the device sits in configuration state with registers reachable.
// R2 - Host writes the power-state field; device goes to the encoded state.
// R3 - Active state converts continuously, first conversion about 10 us after entry.
// R4 - Active state offers continuous and triggered conversion by mode select.
// R5 - Standby accepts commands, converts only on trigger after about 35 us.
// R6 - Configuration state converts on trigger after standby latency plus 35 us.
// R7 - Wake-up-and-sleep converts periodically at 1 to 1000 ms intervals.
// R8 - Sleep keeps configuration and results, performs no measurements.
// R9 - Serial access or host-driven alert wakes the device from sleep.
// R10 - Leaving any sleep state returns to configuration after wake latency.
// R11 - Deep sleep restores all settings and results to reset defaults.
// R12 - Conversion starts are ignored during deep sleep.
// R13 - Wake-up-and-sleep may flag data-ready on alert when enabled.
// R14 - Alert can be limited to conversions crossing a threshold.
// R15 - Triggered conversion starts only from the selected trigger source.
// R16 - Conversion time depends on axes, averaging and self-test settings; here it ends on conv_done and meas_cyc never delays a start.
// R17 - Host may wake device during wake-up-and-sleep and read results.
// R18 - Host uses plain sleep for intervals the periodic wake lacks.
// R19 - Threshold crossing toggles alert when enabled and sets status bit.
// R20 - Latencies are parameters counted in clock cycles.
// R21 - Wake interval timed by low-power tick counter, chosen by a field.
// R22 - Mode field decode is parameterised; reserved codes mean configuration.
`timescale 1ns/1ps
`default_nettype none
`include "somc_defs.svh"
module somc_top #(
	parameter logic [31:0] ACT_START_CYC  = `SOMC_ACT_START_CYC, // [R20]
	parameter logic [31:0] STBY_START_CYC = `SOMC_STBY_START_CYC,
	parameter logic [31:0] CFG_STBY_CYC   = `SOMC_CFG_STBY_CYC,
	parameter logic [31:0] WAKE_CYC       = `SOMC_WAKE_CYC,
	parameter logic [31:0] MEAS_BASE_CYC  = `SOMC_MEAS_BASE_CYC,
	parameter logic [31:0] LF_TICK_CYC    = `SOMC_LF_TICK_CYC,
	parameter logic [2:0]  CODE_CFG       = `SOMC_CODE_CFG,
	parameter logic [2:0]  CODE_STBY      = `SOMC_CODE_STBY,
	parameter logic [2:0]  CODE_ACT_CONT  = `SOMC_CODE_ACT_CONT,
	parameter logic [2:0]  CODE_ACT_TRIG  = `SOMC_CODE_ACT_TRIG,
	parameter logic [2:0]  CODE_WAKES     = `SOMC_CODE_WAKE_SLEEP,
	parameter logic [2:0]  CODE_SLEEP     = `SOMC_CODE_SLEEP,
	parameter logic [2:0]  CODE_DEEP      = `SOMC_CODE_DEEP_SLEEP
) (
	input  wire logic        pclk,
	input  wire logic        presetn,
	input  wire logic        psel,
	input  wire logic        penable,
	input  wire logic        pwrite,
	input  wire logic [11:0] paddr,
	input  wire logic [31:0] pwdata,
	output logic      [31:0] prdata,
	output logic             pready,
	output logic             pslverr,
	input  wire logic        cs_n_pin,
	input  wire logic        alert_in_pin,
	output logic             alert_n_out,
	output logic             alert_n_oe,
	output logic             conv_start,
	output logic             conv_busy,
	input  wire logic        conv_done,
	input  wire logic        conv_thr_cross,
	input  wire logic [15:0] conv_result,
	output logic      [2:0]  op_state
);
	////////////////////////////////////////////////////////////////////////
	// Pin synchronisers, change taken when stages two and three agree
	logic [2:0] cs_sync_ff,  nxt_cs_sync;
	logic [2:0] al_sync_ff,  nxt_al_sync;
	logic       cs_ff,       nxt_cs;
	logic       al_ff,       nxt_al;
	always_comb begin
		nxt_cs_sync = {cs_sync_ff[1:0], cs_n_pin};
		nxt_al_sync = {al_sync_ff[1:0], alert_in_pin};
		nxt_cs = (cs_sync_ff[1] == cs_sync_ff[2]) ? cs_sync_ff[2] : cs_ff;
		nxt_al = (al_sync_ff[1] == al_sync_ff[2]) ? al_sync_ff[2] : al_ff;
	end
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			cs_sync_ff <= 3'h7;
			al_sync_ff <= 3'h0;
			cs_ff      <= 1'b1;
			al_ff      <= 1'b0;
		end else begin
			cs_sync_ff <= nxt_cs_sync;
			al_sync_ff <= nxt_al_sync;
			cs_ff      <= nxt_cs;
			al_ff      <= nxt_al;
		end
	end
	logic cs_fall;
	logic al_rise;
	assign cs_fall = cs_ff && !nxt_cs;
	assign al_rise = !al_ff && nxt_al;
	////////////////////////////////////////////////////////////////////////
	// Registers: ctrl[2:0] mode; conv[2:0] axes, [4:3] avg, [6:5] sched,
	// [7] selftest, [9:8] trig source, [13:10] interval; alert[0] ready en,
	// [1] threshold only, [2] threshold en; ctrl write of 1 to bit 8 = soft trigger
	somc_pkg::somc_state_t state_ff, nxt_state;
	logic [31:0] ctrl_ff,  nxt_ctrl;
	logic [31:0] conv_ff,  nxt_conv;
	logic [31:0] alrt_ff,  nxt_alrt;
	logic [15:0] res_ff,   nxt_res;
	logic        thr_ff,   nxt_thr;
	logic        rdy_ff,   nxt_rdy;
	logic        alert_ff, nxt_alert;
	logic [31:0] cnt_ff,   nxt_cnt;
	logic [31:0] lf_ff,    nxt_lf;
	logic [9:0]  ticks_ff, nxt_ticks;
	logic        pend_ff,  nxt_pend;
	logic        busy_ff,  nxt_busy;
	logic        start_ff, nxt_start;
	logic [31:0] rdata_ff, nxt_rdata;
	logic        err_ff,   nxt_err;
	logic        wr, rd, mapped, soft_trig, trig, wake_req;
	logic [2:0]  mode;
	logic [9:0]  interval_ms;
	logic [31:0] meas_cyc;
	assign wr     = psel && penable && pwrite;
	assign rd     = psel && !penable && !pwrite;
	assign mapped = (paddr == `SOMC_ADDR_CTRL) || (paddr == `SOMC_ADDR_CONV) ||
		(paddr == `SOMC_ADDR_ALERT) || (paddr == `SOMC_ADDR_STATUS) || (paddr == `SOMC_ADDR_RESULT);
	assign soft_trig = wr && (paddr == `SOMC_ADDR_CTRL) && pwdata[8];
	assign mode = ctrl_ff[2:0];
	always_comb begin
		unique case (somc_pkg::somc_trig_t'(conv_ff[9:8])) // [R15]
			somc_pkg::SOMC_TRIG_REG:   trig = soft_trig;
			somc_pkg::SOMC_TRIG_CS:    trig = cs_fall;
			somc_pkg::SOMC_TRIG_ALERT: trig = al_rise;
			somc_pkg::SOMC_TRIG_NONE:  trig = 1'b0;
		endcase
	end
	always_comb begin
		unique case (conv_ff[13:10]) // [R7] [R21]
			4'h0:    interval_ms = 10'd1;
			4'h1:    interval_ms = 10'd5;
			4'h2:    interval_ms = 10'd10;
			4'h3:    interval_ms = 10'd15;
			4'h4:    interval_ms = 10'd20;
			4'h5:    interval_ms = 10'd30;
			4'h6:    interval_ms = 10'd100;
			4'h7:    interval_ms = 10'd500;
			default: interval_ms = 10'd1000;
		endcase
	end
	// Axes count plus one times averaging, plus base shifted by [6:5] with self-test [R16]
	always_comb begin
		meas_cyc = MEAS_BASE_CYC * (32'(conv_ff[0]) + 32'(conv_ff[1]) + 32'(conv_ff[2]) + 32'd1);
		meas_cyc = meas_cyc << conv_ff[4:3];
		if (conv_ff[7])
			meas_cyc = meas_cyc + (MEAS_BASE_CYC << conv_ff[6:5]);
	end
	assign wake_req = cs_fall || al_rise; // [R9] [R17]
	always_comb begin
		nxt_state = state_ff;
		nxt_ctrl  = ctrl_ff;
		nxt_conv  = conv_ff;
		nxt_alrt  = alrt_ff;
		nxt_res   = res_ff;
		nxt_thr   = thr_ff;
		nxt_rdy   = rdy_ff;
		nxt_alert = alert_ff;
		nxt_cnt   = (cnt_ff != 32'h0) ? cnt_ff - 32'h1 : 32'h0;
		nxt_lf    = lf_ff;
		nxt_ticks = ticks_ff;
		nxt_pend  = pend_ff;
		nxt_busy  = busy_ff;
		nxt_start = 1'b0;
		nxt_rdata = rdata_ff;
		nxt_err   = 1'b0;
		if (rd) begin
			unique case (paddr)
				`SOMC_ADDR_CTRL:   nxt_rdata = ctrl_ff;
				`SOMC_ADDR_CONV:   nxt_rdata = conv_ff;
				`SOMC_ADDR_ALERT:  nxt_rdata = alrt_ff;
				`SOMC_ADDR_STATUS: nxt_rdata = {26'h0, busy_ff, rdy_ff, thr_ff, state_ff};
				`SOMC_ADDR_RESULT: nxt_rdata = {16'h0, res_ff};
				default:           nxt_rdata = 32'h0;
			endcase
		end
		if (psel && !penable)
			nxt_err = !mapped;
		if (wr && mapped && state_ff != somc_pkg::SOMC_WAKEUP) begin
			unique case (paddr)
				`SOMC_ADDR_CTRL:   nxt_ctrl = {29'h0, pwdata[2:0]}; // [R2]
				`SOMC_ADDR_CONV:   nxt_conv = {18'h0, pwdata[13:0]};
				`SOMC_ADDR_ALERT:  nxt_alrt = {29'h0, pwdata[2:0]};
				`SOMC_ADDR_STATUS: begin
					nxt_thr = thr_ff && !pwdata[2];
					nxt_rdy = rdy_ff && !pwdata[3];
				end
				default: ;
			endcase
		end
		// Conversion progress
		if (busy_ff && conv_done) begin
			nxt_busy = 1'b0;
			nxt_res  = conv_result;
			nxt_rdy  = 1'b1;
			if (conv_thr_cross && alrt_ff[2]) begin
				nxt_thr   = 1'b1; // [R19]
				nxt_alert = !alert_ff; // [R19]
			end else if (state_ff == somc_pkg::SOMC_WAKES && alrt_ff[0] && !alrt_ff[1])
				nxt_alert = !alert_ff; // [R13] [R14]
		end
		if (pend_ff && cnt_ff == 32'h0 && !busy_ff && mode != CODE_SLEEP && mode != CODE_DEEP) begin // [R8] [R12]
			nxt_pend  = 1'b0;
			nxt_start = 1'b1;
			nxt_busy  = 1'b1;
			nxt_cnt   = meas_cyc;
		end
		unique case (state_ff)
			somc_pkg::SOMC_CFG, somc_pkg::SOMC_STBY: begin
				if (trig && !pend_ff && !busy_ff) begin
					nxt_pend = 1'b1;
					nxt_cnt  = (state_ff == somc_pkg::SOMC_CFG) ?
						CFG_STBY_CYC + STBY_START_CYC : STBY_START_CYC; // [R5] [R6]
				end
			end
			somc_pkg::SOMC_ACT: begin
				if (mode == CODE_ACT_CONT && !pend_ff && !busy_ff && !nxt_busy) begin
					nxt_pend = 1'b1; // [R3] [R4]
					nxt_cnt  = 32'h0;
				end else if (mode == CODE_ACT_TRIG && trig && !pend_ff && !busy_ff) begin
					nxt_pend = 1'b1; // [R4]
					nxt_cnt  = ACT_START_CYC;
				end
			end
			somc_pkg::SOMC_WAKES: begin
				nxt_lf = (lf_ff >= LF_TICK_CYC - 32'h1) ? 32'h0 : lf_ff + 32'h1;
				if (lf_ff >= LF_TICK_CYC - 32'h1) begin
					if (ticks_ff >= interval_ms - 10'd1) begin
						nxt_ticks = 10'h0;
						if (!busy_ff && !pend_ff) begin
							nxt_pend = 1'b1; // [R7] [R21]
							nxt_cnt  = CFG_STBY_CYC + STBY_START_CYC;
						end
					end else
						nxt_ticks = ticks_ff + 10'd1;
				end
			end
			default: ;
		endcase
		// Mode decode, reserved codes fall back to configuration [R22]
		if (state_ff != somc_pkg::SOMC_WAKEUP && state_ff != somc_pkg::SOMC_SLEEP &&
			state_ff != somc_pkg::SOMC_DEEP && state_ff != somc_pkg::SOMC_WAKES) begin
			if (mode == CODE_STBY)
				nxt_state = somc_pkg::SOMC_STBY;
			else if (mode == CODE_ACT_CONT || mode == CODE_ACT_TRIG) begin
				if (state_ff != somc_pkg::SOMC_ACT) begin
					nxt_cnt  = ACT_START_CYC; // [R3]
					nxt_pend = nxt_pend || (mode == CODE_ACT_CONT);
				end
				nxt_state = somc_pkg::SOMC_ACT;
			end else if (mode == CODE_WAKES) begin
				nxt_state = somc_pkg::SOMC_WAKES;
				nxt_lf    = 32'h0;
				nxt_ticks = 10'h0;
			end else if (mode == CODE_SLEEP) begin
				nxt_state = somc_pkg::SOMC_SLEEP; // [R8]
				nxt_pend  = 1'b0;
			end else if (mode == CODE_DEEP) begin
				nxt_state = somc_pkg::SOMC_DEEP;
				nxt_ctrl  = `SOMC_CTRL_RST; // [R11]
				nxt_conv  = `SOMC_CONV_RST;
				nxt_alrt  = `SOMC_ALERT_RST;
				nxt_res   = 16'h0;
				nxt_thr   = 1'b0;
				nxt_rdy   = 1'b0;
				nxt_pend  = 1'b0; // [R12]
			end else
				nxt_state = somc_pkg::SOMC_CFG; // [R1] [R2]
		end
		if ((state_ff == somc_pkg::SOMC_SLEEP || state_ff == somc_pkg::SOMC_DEEP ||
			state_ff == somc_pkg::SOMC_WAKES) && (wake_req || (wr && mapped))) begin
			nxt_state = somc_pkg::SOMC_WAKEUP; // [R9] [R10]
			nxt_cnt   = WAKE_CYC;
			nxt_pend  = 1'b0;
		end
		if (state_ff == somc_pkg::SOMC_WAKEUP && cnt_ff == 32'h0) begin
			nxt_state = somc_pkg::SOMC_CFG; // [R10]
			nxt_ctrl  = {29'h0, CODE_CFG};
		end
	end
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			state_ff <= somc_pkg::SOMC_CFG; // [R1]
			ctrl_ff  <= `SOMC_CTRL_RST;
			conv_ff  <= `SOMC_CONV_RST;
			alrt_ff  <= `SOMC_ALERT_RST;
			res_ff   <= 16'h0;
			thr_ff   <= 1'b0;
			rdy_ff   <= 1'b0;
			alert_ff <= 1'b0;
			cnt_ff   <= 32'h0;
			lf_ff    <= 32'h0;
			ticks_ff <= 10'h0;
			pend_ff  <= 1'b0;
			busy_ff  <= 1'b0;
			start_ff <= 1'b0;
			rdata_ff <= 32'h0;
			err_ff   <= 1'b0;
		end else begin
			state_ff <= nxt_state;
			ctrl_ff  <= nxt_ctrl;
			conv_ff  <= nxt_conv;
			alrt_ff  <= nxt_alrt;
			res_ff   <= nxt_res;
			thr_ff   <= nxt_thr;
			rdy_ff   <= nxt_rdy;
			alert_ff <= nxt_alert;
			cnt_ff   <= nxt_cnt;
			lf_ff    <= nxt_lf;
			ticks_ff <= nxt_ticks;
			pend_ff  <= nxt_pend;
			busy_ff  <= nxt_busy;
			start_ff <= nxt_start;
			rdata_ff <= nxt_rdata;
			err_ff   <= nxt_err;
		end
	end
	assign prdata      = rdata_ff;
	assign pready      = 1'b1;
	assign pslverr     = err_ff && psel && penable;
	assign alert_n_out = 1'b0;
	assign alert_n_oe  = alert_ff;
	assign conv_start  = start_ff;
	assign conv_busy   = busy_ff;
	assign op_state    = state_ff;
endmodule
`default_nettype wire

// file: bench/somc_asserts.sv
// Purpose: Port assertions of the mode controller
// Assumes: bench parameters, mode codes at defaults
// Notes:   Bound to every somc_top
`timescale 1ns/1ps
`default_nettype none
module somc_asserts #(
	parameter logic [31:0] WAKE_CYC = 32'h0000000A
) (
	input wire logic        pclk,
	input wire logic        presetn,
	input wire logic        psel,
	input wire logic        penable,
	input wire logic        pwrite,
	input wire logic [11:0] paddr,
	input wire logic [31:0] pwdata,
	input wire logic        pslverr,
	input wire logic        cs_n_pin,
	input wire logic        alert_n_out,
	input wire logic        alert_n_oe,
	input wire logic        conv_done,
	input wire logic        conv_start,
	input wire logic [2:0]  op_state
);
	logic [31:0] wcnt_ff;
	logic        wr0;
	assign wr0 = psel && penable && pwrite && paddr == 12'h000;
	// Cycles spent waking
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn)
			wcnt_ff <= 32'h00000000;
		else
			wcnt_ff <= (op_state == 3'h6) ? wcnt_ff + 32'h00000001 : 32'h00000000;
	end
	default clocking @(posedge pclk); endclocking
	default disable iff (!presetn);
	////////////////////////////////////////////////////////////////////////
	rst_cfg_a: assert property (!$past(presetn) |-> op_state == 3'h0)
		else $error("state not cfg after reset");
	mode_stby_a: assert property (wr0 && pwdata[2:0] == 3'h1 && op_state == 3'h0 |-> ##[1:3] op_state == 3'h1)
		else $error("standby not entered");
	mode_sleep_a: assert property (wr0 && pwdata[2:0] == 3'h5 && op_state < 3'h3 |-> ##[1:3] op_state == 3'h4)
		else $error("sleep not entered");
	rsvd_cfg_a: assert property (wr0 && pwdata[2:0] == 3'h7 && op_state < 3'h3 |-> ##[1:3] op_state == 3'h0)
		else $error("reserved code not cfg");
	sleep_quiet_a: assert property (op_state == 3'h4 |-> !conv_start)
		else $error("conversion in sleep");
	deep_quiet_a: assert property (op_state == 3'h5 |-> !conv_start)
		else $error("conversion in deep sleep");
	cs_wake_a: assert property ($fell(cs_n_pin) && op_state == 3'h4 |-> ##[1:8] op_state == 3'h6)
		else $error("no wake on serial start");
	sleep_exit_a: assert property ($past(op_state) inside {3'h3, 3'h4, 3'h5} && op_state != $past(op_state)
		|-> op_state == 3'h6)
		else $error("sleep left without waking");
	wake_cfg_a: assert property (op_state == 3'h6 ##1 op_state != 3'h6 |-> op_state == 3'h0)
		else $error("waking not ending in cfg");
	wake_len_a: assert property (wcnt_ff <= WAKE_CYC + 32'h00000002)
		else $error("waking too long");
	alert_low_a: assert property (alert_n_out == 1'b0)
		else $error("alert drive level wrong");
	alert_src_a: assert property ($changed(alert_n_oe) |-> $past(conv_done))
		else $error("alert toggled without conversion");
	unmap_err_a: assert property (psel && penable && paddr > 12'h010 |-> pslverr)
		else $error("no error on unmapped");
endmodule
bind somc_top somc_asserts #(.WAKE_CYC(WAKE_CYC)) i_somc_asserts (
	.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata,
	.pslverr, .cs_n_pin, .alert_n_out, .alert_n_oe, .conv_done, .conv_start, .op_state
);
`default_nettype wire

// file: bench/somc_conv_model.sv
// Purpose: Conversion core model answering conv_start
// Assumes: result handed in by the bench
// Notes:   Result line shows inverse outside done
`timescale 1ns/1ps
`default_nettype none
module somc_conv_model (
	input wire logic        pclk,
	input wire logic        presetn,
	input wire logic        conv_start,
	input wire logic        slow,
	input wire logic [15:0] res,
	output logic            conv_done,
	output logic     [15:0] conv_result
);
	logic [7:0]  cnt;
	logic [15:0] last;
	always @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			cnt <= 8'h00;
			conv_done <= 1'b0;
			last <= 16'h0000;
		end else begin
			conv_done <= (cnt == 8'h01);
			if (conv_start)
				cnt <= slow ? 8'h28 : 8'h03;
			else if (cnt != 8'h00)
				cnt <= cnt - 8'h01;
			if (cnt == 8'h01)
				last <= res;
		end
	end
	assign conv_result = conv_done ? last : ~last;
endmodule
`default_nettype wire

// file: bench/testbench.sv
// Purpose: Self-checking bench of the mode controller
// Assumes: shortened latencies below
// Notes:   Reads are checked from a queue of notes
`timescale 1ns/1ps
`default_nettype none
module testbench;
	localparam int STBY = 20;
	localparam int CFGL = 10;
	localparam int ACTL = 5;
	logic        pclk;
	logic        presetn;
	logic        psel;
	logic        penable;
	logic        pwrite;
	logic [11:0] paddr;
	logic [31:0] pwdata;
	logic [31:0] prdata;
	logic        pready;
	logic        pslverr;
	logic        cs_n_pin;
	logic        alert_in_pin;
	logic        alert_n_out;
	logic        alert_n_oe;
	logic        conv_start;
	logic        conv_busy;
	logic        conv_done;
	logic [15:0] conv_result;
	logic [2:0]  op_state;
	logic        slow;
	logic        thr;
	logic [15:0] res;
	logic [15:0] rnd;
	logic [32:0] notes[$];
	logic [32:0] e;
	logic        oe0;
	logic [2:0]  mcode[5] = '{3'h0, 3'h1, 3'h2, 3'h3, 3'h7};
	logic [2:0]  mst[5] = '{3'h0, 3'h1, 3'h2, 3'h2, 3'h0};
	logic [2:0]  tm[3] = '{3'h0, 3'h1, 3'h3};
	int          tl[3] = '{CFGL + STBY, STBY, ACTL};
	int          failures;
	int          n_checks;
	int          cyc;
	int          k;
	int          n;
	somc_top #(.ACT_START_CYC(ACTL), .STBY_START_CYC(STBY), .CFG_STBY_CYC(CFGL),
		.WAKE_CYC(10), .LF_TICK_CYC(20)) i_somc_top (
		.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata, .pready,
		.pslverr, .cs_n_pin, .alert_in_pin, .alert_n_out, .alert_n_oe, .conv_start,
		.conv_busy, .conv_done, .conv_thr_cross(thr), .conv_result, .op_state
	);
	somc_conv_model i_somc_conv_model (
		.pclk, .presetn, .conv_start, .slow, .res, .conv_done, .conv_result
	);
	////////////////////////////////////////////////////////////////////////
	function automatic logic [15:0] lfsr(input logic [15:0] x);
		return {x[14:0], x[15] ^ x[13] ^ x[12] ^ x[10]};
	endfunction
	task automatic chk(input string nm, input logic [31:0] ex, input logic [31:0] sn);
		n_checks++;
		if (sn !== ex) begin
			failures++;
			$display("[FAIL] %s expected %h seen %h", nm, ex, sn);
		end
	endtask
	task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
		@(posedge pclk);
		psel <= 1'b1;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge pclk);
		penable <= 1'b1;
		do
			@(posedge pclk);
		while (pready !== 1'b1);
		psel <= 1'b0;
		penable <= 1'b0;
	endtask
	task automatic rd(input logic [11:0] a, input logic [32:0] ex);
		notes.push_back(ex);
		apb(1'b0, a, 32'h00000000);
	endtask
	task automatic wait_st(input logic [2:0] s);
		for (int j = 0; j < 100 && op_state !== s; j++)
			@(posedge pclk);
		chk("op_state", {29'h0, s}, {29'h0, op_state});
	endtask
	task automatic wait_go(input int lim);
		n = 0;
		while (conv_start !== 1'b1 && n < lim) begin
			@(posedge pclk);
			n++;
		end
	endtask
	task automatic pin_pulse(input logic cs);
		if (cs)
			cs_n_pin <= 1'b0;
		else
			alert_in_pin <= 1'b1;
		repeat (4) @(posedge pclk);
		cs_n_pin <= 1'b1;
		alert_in_pin <= 1'b0;
	endtask
	task automatic idle();
		@(posedge pclk);
		while (conv_busy !== 1'b0)
			@(posedge pclk);
	endtask
	task automatic close_out();
		$display("checks %0d failures %0d", n_checks, failures);
		if (failures == 0 && n_checks > 0)
			$display("SIMULATION PASSED");
		else
			$display("SIMULATION FAILED");
		$finish;
	endtask
	////////////////////////////////////////////////////////////////////////
	initial begin
		pclk = 1'b0;
		forever #2.5 pclk = ~pclk;
	end
	// Read checker
	always @(posedge pclk) begin
		if (psel && penable && !pwrite && pready === 1'b1 && notes.size() > 0) begin
			e = notes.pop_front();
			if (e[32])
				chk("rd_err", 32'h1, {31'h0, pslverr});
			else
				chk(paddr == 12'h010 ? "result" : "rd_data", e[31:0], prdata);
		end
	end
	always @(posedge pclk) begin
		cyc++;
		if (cyc == 20000) begin
			failures++;
			close_out();
		end
	end
	initial begin
		{psel, penable, pwrite, alert_in_pin, slow, thr} = 6'h00;
		paddr = 12'h000;
		pwdata = 32'h00000000;
		cs_n_pin = 1'b1;
		res = 16'h0000;
		rnd = 16'h0059;
		presetn = 1'b0;
		failures = 0;
		n_checks = 0;
		cyc = 0;
		repeat (10) @(posedge pclk);
		presetn <= 1'b1;
		wait_st(3'h0);
		rd(12'h000, 33'h000000000);
		rd(12'h004, 33'h000000007);
		rd(12'h020, 33'h100000000);
		$display("test reset done");
		for (k = 0; k < 5; k++) begin
			apb(1'b1, 12'h000, {29'h0, mcode[k]});
			if (k == 2) begin
				wait_go(40);
				chk("act_lat", 32'h1, {31'h0, n >= ACTL && n <= ACTL + 4});
			end
			wait_st(mst[k]);
		end
		rnd = lfsr(rnd);
		apb(1'b1, 12'h004, {18'h0, rnd[13:10], 2'h0, rnd[7:0]});
		rd(12'h004, {19'h0, rnd[13:10], 2'h0, rnd[7:0]});
		$display("test modes done");
		apb(1'b1, 12'h004, 32'h00000007);
		for (k = 0; k < 3; k++) begin
			apb(1'b1, 12'h000, {29'h0, tm[k]});
			wait_st(mst[tm[k]]);
			rnd = lfsr(rnd);
			res <= rnd;
			apb(1'b1, 12'h000, {23'h0, 1'b1, 5'h0, tm[k]});
			wait_go(400);
			chk("trig_lat", 32'h1, {31'h0, n >= tl[k] && n <= tl[k] + 4});
			idle();
			rd(12'h010, {17'h0, rnd});
		end
		apb(1'b1, 12'h004, 32'h00000307);
		apb(1'b1, 12'h000, 32'h00000103);
		wait_go(60);
		chk("no_start", 32'h3C, n);
		apb(1'b1, 12'h004, 32'h00000107);
		pin_pulse(1'b1);
		wait_go(60);
		chk("cs_start", 32'h1, {31'h0, n < 60});
		idle();
		apb(1'b1, 12'h004, 32'h00000207);
		pin_pulse(1'b0);
		wait_go(60);
		chk("al_start", 32'h1, {31'h0, n < 60});
		idle();
		$display("test triggers done");
		apb(1'b1, 12'h000, 32'h00000005);
		wait_st(3'h4);
		repeat (30) @(posedge pclk);
		pin_pulse(1'b1);
		wait_st(3'h6);
		wait_st(3'h0);
		rd(12'h004, 33'h000000207);
		rd(12'h010, {17'h0, rnd});
		apb(1'b1, 12'h000, 32'h00000006);
		wait_st(3'h5);
		pin_pulse(1'b0);
		wait_st(3'h6);
		wait_st(3'h0);
		rd(12'h004, 33'h000000007);
		rd(12'h010, 33'h000000000);
		rd(12'h000, 33'h000000000);
		$display("test sleep done");
		slow <= 1'b1;
		rnd = lfsr(rnd);
		res <= rnd;
		apb(1'b1, 12'h008, 32'h00000001);
		oe0 = alert_n_oe;
		apb(1'b1, 12'h000, 32'h00000004);
		wait_st(3'h3);
		wait_go(200);
		chk("ws_start", 32'h1, {31'h0, n < 200});
		idle();
		repeat (3) @(posedge pclk);
		chk("alert_oe", {31'h0, ~oe0}, {31'h0, alert_n_oe});
		pin_pulse(1'b0);
		wait_st(3'h0);
		rd(12'h010, {17'h0, rnd});
		$display("test wake sleep done");
		thr <= 1'b1;
		apb(1'b1, 12'h008, 32'h00000006);
		oe0 = alert_n_oe;
		apb(1'b1, 12'h000, 32'h00000100);
		wait_go(400);
		idle();
		chk("alert_thr", {31'h0, ~oe0}, {31'h0, alert_n_oe});
		rd(12'h00C, 33'h000000018);
		thr <= 1'b0;
		apb(1'b1, 12'h008, 32'h00000003);
		oe0 = alert_n_oe;
		apb(1'b1, 12'h000, 32'h00000004);
		wait_st(3'h3);
		wait_go(200);
		idle();
		repeat (3) @(posedge pclk);
		chk("alert_hold", {31'h0, oe0}, {31'h0, alert_n_oe});
		pin_pulse(1'b0);
		wait_st(3'h0);
		$display("test alert done");
		repeat (5) @(posedge pclk);
		close_out();
	end
endmodule
`default_nettype wire
